// File: rtl/bist_pkg.sv
// constants for the serial link self-test checker
// Behaviour
// R1: far end sends seven-bit pseudo-random pattern
// R2: check every payload against that pattern
// R3: flag payloads with one to 24 bad bits
// R4: select low gives final only, high adds pulses
// R5: each errored payload pulses result low
// R6: final result high clean, low on errors
// R7: hold result until new test, reset, power-down
// R8: enable high starts self test checking
// R9: enable low stops checking, latches outcome
// R10: pattern plus command turns display outputs off
// R11: far end drops its enable to resume
// R12: pinless far end enters test on zeros
// R13: drive enable low: display off, result active
// R14: local reference synced, compared every cycle
package bist_pkg;
  localparam int unsigned PAYLOAD_W = 24;
  localparam int unsigned SEED_W = 7;
  localparam int unsigned SEED_LSB = 17;
  localparam int unsigned CNT_W = 16;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_ERRCNT = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_MODE = 1;
  localparam int unsigned CTRL_PDN = 2;
  localparam int unsigned CTRL_DRIVE = 3;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  localparam int unsigned IRQ_ERR = 0;
  localparam int unsigned IRQ_DONE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic addr_ok(input logic [4:0] a);
    addr_ok = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_ERRCNT)
      || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
  endfunction
endpackage

// File: rtl/prbs7_ref.sv
// reference pattern step: 24 expected bits from seven bits of history
`timescale 1ns/10ps
`default_nettype none
module prbs7_ref
  import bist_pkg::*;
(
  input wire logic [SEED_W-1:0] state,
  output logic [PAYLOAD_W-1:0] expect_bits,
  output logic [SEED_W-1:0] state_nxt
);
  logic [SEED_W-1:0] s;
  logic nb;

  // x^7 + x^6 + 1, bit 0 of the payload first
  always_comb
  begin
    s = state;
    nb = 1'b0;
    expect_bits = '0;
    for (int i = 0; i < PAYLOAD_W; i++)
    begin
      nb = s[1] ^ s[0];
      expect_bits[i] = nb;
      s = {nb, s[SEED_W-1:1]};
    end
    state_nxt = s;
  end
endmodule
`default_nettype wire

// File: rtl/axil_port.sv
// axi4-lite slave handshake: write strobe and read capture
`timescale 1ns/10ps
`default_nettype none
module axil_port
  import bist_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] rd_data,
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_byte
);
  logic aw_have_r;
  logic w_have_r;
  logic [4:0] aw_addr_r;
  logic [7:0] w_byte_r;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= '0;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_byte <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      wr_en <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_byte_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (aw_have_r && w_have_r)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        wr_en <= addr_ok(aw_addr_r) && (w_byte_r != 8'h00 || 1'b1);
        wr_addr <= aw_addr_r;
        wr_byte <= w_byte_r;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read data captured when the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// File: rtl/link_bist_checker.sv
// self-test checker of the serial link receiver with register port
`timescale 1ns/10ps
`default_nettype none
module link_bist_checker
  import bist_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PAYLOAD_W-1:0] link_payload,
  input wire logic link_valid,
  input wire logic link_control_bit_a,
  input wire logic link_control_bit_b,
  input wire logic link_lock,
  output logic test_result,
  output logic test_result_oe,
  output logic oversample_oe,
  output logic display_oe,
  output logic irq
);
  logic [3:0] ctrl_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] irq_mask_r;
  logic active_r;
  logic locked_r;
  logic err_seen_r;
  logic cmd_r;
  logic [CNT_W-1:0] err_cnt_r;
  logic [SEED_W-1:0] ref_state_r;
  logic [SEED_W-1:0] ref_state_nxt;
  logic [PAYLOAD_W-1:0] expect_bits;
  logic [31:0] rd_data;
  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_byte;
  logic self_test_enable;
  logic result_report_select;
  logic power_down_n;
  logic display_output_drive_enable;
  logic start;
  logic stop;
  logic chk;
  logic bad;

  axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_byte(wr_byte)
  );

  prbs7_ref u_ref (
    .state(ref_state_r),
    .expect_bits(expect_bits),
    .state_nxt(ref_state_nxt)
  );

  assign self_test_enable = ctrl_r[CTRL_EN];
  assign result_report_select = ctrl_r[CTRL_MODE];
  assign power_down_n = ctrl_r[CTRL_PDN];
  assign display_output_drive_enable = ctrl_r[CTRL_DRIVE];

  // test window edges and per-payload check
  assign start = self_test_enable && power_down_n && !active_r; // see R8
  assign stop = active_r && !(self_test_enable && power_down_n); // see R9
  assign chk = active_r && self_test_enable && power_down_n && link_valid && locked_r; // see R14
  assign bad = chk && (link_payload != expect_bits); // see R3

  // control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= CTRL_RESET;
    else if (wr_en && wr_addr == OFF_CTRL)
      ctrl_r <= wr_byte[3:0];
  end

  // test window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_r <= 1'b0;
    else
      active_r <= self_test_enable && power_down_n; // see R8, R9
  end

  // reference pattern: seed from the stream, then free-run
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      locked_r <= 1'b0;
      ref_state_r <= '0;
    end
    else if (start || !power_down_n)
      locked_r <= 1'b0;
    else if (active_r && self_test_enable && link_valid)
    begin
      locked_r <= 1'b1; // see R2, R14
      ref_state_r <= locked_r ? ref_state_nxt : link_payload[SEED_LSB +: SEED_W]; // see R14
    end
  end

  // error memory and count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      err_seen_r <= 1'b0;
      err_cnt_r <= '0;
    end
    else if (start || !power_down_n)
    begin
      err_seen_r <= 1'b0;
      err_cnt_r <= '0;
    end
    else if (bad)
    begin
      err_seen_r <= 1'b1; // see R3
      if (err_cnt_r != {CNT_W{1'b1}})
        err_cnt_r <= err_cnt_r + 1'b1;
    end
  end

  // result pin: pulses during test when select is high, held outcome after
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      test_result <= 1'b1;
    else if (!power_down_n || start)
      test_result <= 1'b1; // see R7
    else if (stop)
      test_result <= !err_seen_r; // see R6, R9
    else if (active_r)
      test_result <= !(bad && result_report_select); // see R4, R5
  end

  // test command on the control bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmd_r <= 1'b0;
    else if (link_valid)
      cmd_r <= link_control_bit_a && link_control_bit_b;
  end

  // pin drive enables
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      test_result_oe <= 1'b0;
      oversample_oe <= 1'b0;
      display_oe <= 1'b0;
    end
    else
    begin
      test_result_oe <= power_down_n && link_lock; // see R13
      oversample_oe <= power_down_n && link_lock; // see R13
      display_oe <= power_down_n && link_lock && display_output_drive_enable
        && !(cmd_r && locked_r); // see R10, R13
    end
  end

  // sticky events, write one to clear, set wins
  always_comb
  begin
    irq_stat_nxt = irq_stat_r;
    if (wr_en && wr_addr == OFF_IRQ_STAT)
      irq_stat_nxt = irq_stat_nxt & ~wr_byte[1:0];
    if (bad)
      irq_stat_nxt[IRQ_ERR] = 1'b1;
    if (stop)
      irq_stat_nxt[IRQ_DONE] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en && wr_addr == OFF_IRQ_MASK)
        irq_mask_r <= wr_byte[1:0];
      irq <= |(irq_stat_nxt & ((wr_en && wr_addr == OFF_IRQ_MASK) ? wr_byte[1:0] : irq_mask_r));
    end
  end

  // read mux
  always_comb
  begin
    rd_data = '0;
    unique case (s_axi_araddr)
      OFF_CTRL: rd_data[3:0] = ctrl_r;
      OFF_STATUS: rd_data[3:0] = {link_lock, active_r, locked_r, test_result};
      OFF_ERRCNT: rd_data[CNT_W-1:0] = err_cnt_r;
      OFF_IRQ_STAT: rd_data[1:0] = irq_stat_r;
      OFF_IRQ_MASK: rd_data[1:0] = irq_mask_r;
      default: rd_data = '0;
    endcase
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_pulse_on_error: assert property (bad && result_report_select && !stop |=> !test_result) // see R5
    else $error("no low pulse for errored payload");
  a_quiet_mode: assert property (active_r && $past(active_r) && !result_report_select && !stop
    && !$past(stop) |-> test_result) // see R4
    else $error("result moved during test in final-only mode");
  a_pulse_ends: assert property (active_r && !bad && !stop && !start |=> test_result) // see R5
    else $error("result stayed low without a new error");
  a_final_value: assert property (stop && power_down_n |=> test_result == !$past(err_seen_r)) // see R6
    else $error("final result does not match error history");
  a_result_held: assert property (!active_r && !start && power_down_n && $past(!active_r)
    |=> $stable(test_result)) // see R7
    else $error("held result changed");
  a_start_clean: assert property (start |=> active_r && !err_seen_r && test_result && !locked_r) // see R8
    else $error("new test did not start clean");
  a_stop_freeze: assert property (!self_test_enable && active_r |=> !active_r ##1 $stable(err_cnt_r)) // see R9
    else $error("checking continued after enable dropped");
  a_error_flag: assert property (bad |=> err_seen_r && irq_stat_r[IRQ_ERR]) // see R3
    else $error("errored payload not recorded");
  a_seed_lock: assert property (active_r && self_test_enable && link_valid && !locked_r && !start
    |=> locked_r) // see R14
    else $error("reference did not lock to stream");
  a_display_off: assert property (cmd_r && locked_r |=> !display_oe) // see R10
    else $error("display left on during test command");
  a_pass_drive: assert property (power_down_n && link_lock |=> test_result_oe) // see R13
    else $error("result pin not driven while locked");

  c_error_pulse: cover property (bad && result_report_select ##1 !test_result ##1 test_result);
  c_clean_pass: cover property (stop && !err_seen_r ##1 test_result);
  c_fail: cover property (stop && err_seen_r ##1 !test_result);
  c_display_shut: cover property (display_oe ##1 !display_oe && cmd_r);
endmodule
`default_nettype wire

// File: dv/prbs_source.sv
// far-end serializer model sending the seven-bit pseudo-random pattern
`timescale 1ns/10ps
`default_nettype none
module prbs_source
#(
  parameter logic [6:0] SEED = 7'h5a
)
(
  input wire logic aclk,
  input wire logic cmd,
  input wire logic [23:0] flip,
  output logic [23:0] link_payload,
  output logic link_valid,
  output logic link_control_bit_a,
  output logic link_control_bit_b
);
  logic [6:0] st = SEED;
  logic [23:0] p;
  initial
  begin
    link_payload = 24'h000000;
    link_valid = 1'b0;
    link_control_bit_a = 1'b0;
    link_control_bit_b = 1'b0;
  end
  // pattern at full rate, bit 0 first, errors only where flip asks
  // pixel clock runs in every case
  always @(posedge aclk)
  begin
    for (int i = 0; i < 24; i++)
    begin
      p[i] = st[6] ^ st[5];
      st = {st[5:0], p[i]};
    end
    link_payload <= p ^ flip;
    link_valid <= 1'b1;
    link_control_bit_a <= cmd;
    link_control_bit_b <= cmd;
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench of the link self-test checker
`timescale 1ns/10ps
`default_nettype none
module tb
  import bist_pkg::*;
;
  logic aclk = 0, aresetn = 0, link_lock = 1, cmd = 0, inw = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic [23:0] flip = 0, link_payload;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic link_valid, link_control_bit_a, link_control_bit_b;
  logic test_result, test_result_oe, oversample_oe, display_oe, irq;
  int fails = 0, cmp_count = 0, cyc = 0, err, lowc, seed = 4;

  always #25 aclk = ~aclk;

  link_bist_checker u_link_bist_checker (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1), .link_payload, .link_valid, .link_control_bit_a,
    .link_control_bit_b, .link_lock, .test_result, .test_result_oe, .oversample_oe, .display_oe, .irq);

  prbs_source u_prbs_source (.aclk, .cmd, .flip, .link_payload, .link_valid, .link_control_bit_a,
    .link_control_bit_b);

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    do @(negedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask

  task automatic axr(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    axr(a, rv);
    chk(rv, e);
  endtask

  // one self test: start, inject, stop, then result and status
  task automatic run_test(input logic mode, input int n, input logic [1:0] mask);
    logic [31:0] r;
    logic [23:0] f;
    axw(OFF_IRQ_MASK, {30'h0, mask});
    axw(OFF_CTRL, {28'h0, 2'b11, mode, 1'b1});
    repeat (4) @(posedge aclk);
    err = 0;
    lowc = 0;
    inw <= 1'b1;
    repeat (n)
    begin
      r = $random(seed);
      f = (r[1:0] == 2'h0) ? (r[2] ? 24'hffffff : r[31:8] | 24'h000001) : 24'h000000;
      flip <= f;
      err += (f != 0);
      @(posedge aclk);
    end
    flip <= 24'h000000;
    @(negedge aclk);
    chk(display_oe, 0);
    repeat (5) @(posedge aclk);
    inw <= 1'b0;
    chk(lowc, mode ? err : 0);
    rdchk(OFF_ERRCNT, err);
    axw(OFF_CTRL, {28'h0, 2'b11, mode, 1'b0});
    @(posedge aclk);
    @(negedge aclk);
    chk(test_result, err == 0);
    repeat (30) @(posedge aclk);
    @(negedge aclk);
    chk(test_result, err == 0);
    @(posedge aclk);
    rdchk(OFF_IRQ_STAT, {30'h0, 1'b1, err != 0});
    chk(irq, |({1'b1, err != 0} & mask));
    axw(OFF_IRQ_STAT, 32'h3);
    rdchk(OFF_IRQ_STAT, 0);
    chk(irq, 0);
  endtask

  always @(negedge aclk)
    if (inw && test_result === 1'b0) lowc++;

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict;
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(OFF_CTRL, CTRL_RESET);
    rdchk(OFF_IRQ_MASK, 0);
    rdchk(OFF_IRQ_STAT, 0);
    axw(5'h14, 32'h1, RESP_SLVERR);
    axr(5'h14, rv, RESP_SLVERR);
    chk(rv, 0);
    cmd <= 1'b1;
    run_test(1'b1, 40, 2'h1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(test_result, 1);
    @(posedge aclk);
    aresetn <= 1'b1;
    run_test(1'b0, 0, 2'h3);
    run_test(1'b0, 40, 2'h0);
    run_test(1'b1, 40, 2'h3);
    cmd <= 1'b0;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(display_oe, 1);
    @(posedge aclk);
    axw(OFF_CTRL, 32'h4);
    @(posedge aclk);
    @(negedge aclk);
    chk({display_oe, test_result_oe, oversample_oe}, 3'b011);
    @(posedge aclk);
    link_lock <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk({test_result_oe, oversample_oe}, 2'b00);
    @(posedge aclk);
    link_lock <= 1'b1;
    axw(OFF_CTRL, 32'h0);
    @(posedge aclk);
    @(negedge aclk);
    chk({test_result, test_result_oe}, 2'b10);
    give_verdict;
  end
endmodule
`default_nettype wire
